// ---- sdfe_cfg.svh ----
// offsets, field positions, reset values and masks of the force event / dma status bank
`ifndef SDFE_CFG_SVH
`define SDFE_CFG_SVH

// ----------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------
`define SDFE_OFS_MAXCAP     8'h00
`define SDFE_OFS_FORCE      8'h04
`define SDFE_OFS_DMA_STAT   8'h08
`define SDFE_OFS_DMA_ADDR   8'h0C

// ----------------------------------------
// max current field
// ----------------------------------------
`define SDFE_MAXCUR_W       8
`define SDFE_MAXCUR_4MA     8'h01
`define SDFE_MAXCUR_8MA     8'h02
`define SDFE_MAXCUR_12MA    8'h03
`define SDFE_MAXCUR_16MA    8'h04

// ----------------------------------------
// force event bit positions
// ----------------------------------------
`define SDFE_B_DMA_ERR      25
`define SDFE_B_AUTOSTOP     24
`define SDFE_B_CUR_LIMIT    23
`define SDFE_B_DAT_ENDBIT   22
`define SDFE_B_DAT_CRC      21
`define SDFE_B_DAT_TIMEOUT  20
`define SDFE_B_CMD_INDEX    19
`define SDFE_B_CMD_ENDBIT   18
`define SDFE_B_CMD_CRC      17
`define SDFE_B_CMD_TIMEOUT  16
`define SDFE_B_AS_NOTISSUED 7
`define SDFE_B_AS_INDEX     4
`define SDFE_B_AS_ENDBIT    3
`define SDFE_B_AS_CRC       2
`define SDFE_B_AS_TIMEOUT   1
`define SDFE_B_AS_NOTEXEC   0
`define SDFE_FORCE_MASK     32'h03FF009F

// ----------------------------------------
// dma error status fields and reset values
// ----------------------------------------
`define SDFE_B_LEN_MISMATCH 2
`define SDFE_STATE_STOP     2'h0
`define SDFE_STATE_FETCH    2'h1
`define SDFE_STATE_XFER     2'h3
`define SDFE_RST_WORD       32'h00000000

`endif

// ---- sdfe_pkg.sv ----
// types shared by the force event / dma status bank
`default_nettype none
package sdfe_pkg;
	typedef logic [31:0] sdfe_word_t;
	typedef logic [1:0]  sdfe_dma_state_t;
endpackage
`default_nettype wire

// ---- sdfe_force_pulse.sv ----
// one-cycle force pulse generator for the write-only force register
`timescale 1ns/100ps
`default_nettype none
`include "sdfe_cfg.svh"
module sdfe_force_pulse
	import sdfe_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       wr_stb,
	input  wire sdfe_word_t wr_data,
	output logic            [31:0] pulse
);
	logic [31:0] next_pulse;

	always_comb
	begin
		// unimplemented positions are masked; zero bits change nothing
		next_pulse = wr_stb ? (wr_data & `SDFE_FORCE_MASK) : 32'h00000000;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pulse <= 32'h00000000;
		else
			pulse <= next_pulse;
	end
endmodule // sdfe_force_pulse
`default_nettype wire

// ---- sdfe_bank.sv ----
// force event, max current, dma error status and dma descriptor pointer registers
//
// Overview of operation
// - read-only 8-bit max current code, 1..4 valid
// - force bit 25 sets dma error flag
// - force bit 24 sets autostop summary error
// - force bit 23 sets current limit error
// - bits 22..20 force data endbit/crc/timeout
// - bits 19..16 force command index/endbit/crc/timeout
// - bits 7,4..0 force autostop detail flags
// - unimplemented force bits read zero, ignore writes
// - hardware-managed length mismatch flag at bit 2
// - two-bit dma state captured on dma error
// - 32-bit descriptor pointer, software and engine writable
`timescale 1ns/100ps
`default_nettype none
`include "sdfe_cfg.svh"
module sdfe_bank
	import sdfe_pkg::*;
#(
	parameter logic [7:0] MAX_CURRENT = `SDFE_MAXCUR_4MA
)
(
	input  wire logic            clk,
	input  wire logic            rst_n,
	// register port
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	input  wire logic [7:0]      reg_addr,
	input  wire sdfe_word_t      reg_wdata,
	output sdfe_word_t           reg_rdata,
	// dma engine side
	input  wire logic            dma_err_event,
	input  wire sdfe_dma_state_t dma_err_state,
	input  wire logic            dma_len_mismatch_set,
	input  wire logic            dma_len_mismatch_clr,
	input  wire logic            dma_ptr_update,
	input  wire sdfe_word_t      dma_ptr_value,
	output sdfe_word_t           dma_descriptor_pointer,
	// force strobes towards interrupt status logic
	output logic                 force_dma_error,
	output logic                 force_autostop_error,
	output logic                 force_current_limit_error,
	output logic                 force_data_endbit_error,
	output logic                 force_data_crc_error,
	output logic                 force_data_timeout_error,
	output logic                 force_cmd_index_error,
	output logic                 force_cmd_endbit_error,
	output logic                 force_cmd_crc_error,
	output logic                 force_cmd_timeout_error,
	output logic                 force_cmd_not_issued_error,
	output logic                 force_autostop_index_error,
	output logic                 force_autostop_endbit_error,
	output logic                 force_autostop_crc_error,
	output logic                 force_autostop_timeout_error,
	output logic                 force_autostop_not_executed
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [31:0]     pulse;
	logic            dma_length_mismatch;
	sdfe_dma_state_t dma_error_state;

	// ----------------------------------------
	// next values and decoded words
	// ----------------------------------------
	logic            next_dma_length_mismatch;
	sdfe_dma_state_t next_dma_error_state;
	sdfe_word_t      next_dma_descriptor_pointer;
	sdfe_word_t      next_reg_rdata;
	sdfe_word_t      maxcap_word;
	sdfe_word_t      dma_stat_word;
	logic            force_wr;
	logic            ptr_wr;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// exact match only: an alias would let a stray write fire force strobes
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	assign force_wr = reg_wr && hit(reg_addr, `SDFE_OFS_FORCE);
	assign ptr_wr   = reg_wr && hit(reg_addr, `SDFE_OFS_DMA_ADDR);

	// ----------------------------------------
	// force pulses
	// ----------------------------------------
	sdfe_force_pulse u_pulse
	(
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_stb  (force_wr),
		.wr_data (reg_wdata),
		.pulse   (pulse)
	);

	// ----------------------------------------
	// interrupt status strobes
	// ----------------------------------------
	// each strobe lasts one cycle; the status logic is expected to latch it

	assign force_dma_error              = pulse[`SDFE_B_DMA_ERR];
	assign force_autostop_error         = pulse[`SDFE_B_AUTOSTOP];
	assign force_current_limit_error    = pulse[`SDFE_B_CUR_LIMIT];
	assign force_data_endbit_error      = pulse[`SDFE_B_DAT_ENDBIT];
	assign force_data_crc_error         = pulse[`SDFE_B_DAT_CRC];
	assign force_data_timeout_error     = pulse[`SDFE_B_DAT_TIMEOUT];
	assign force_cmd_index_error        = pulse[`SDFE_B_CMD_INDEX];
	assign force_cmd_endbit_error       = pulse[`SDFE_B_CMD_ENDBIT];
	assign force_cmd_crc_error          = pulse[`SDFE_B_CMD_CRC];
	assign force_cmd_timeout_error      = pulse[`SDFE_B_CMD_TIMEOUT];

	// ----------------------------------------
	// autostop detail strobes
	// ----------------------------------------
	assign force_cmd_not_issued_error   = pulse[`SDFE_B_AS_NOTISSUED];
	assign force_autostop_index_error   = pulse[`SDFE_B_AS_INDEX];
	assign force_autostop_endbit_error  = pulse[`SDFE_B_AS_ENDBIT];
	assign force_autostop_crc_error     = pulse[`SDFE_B_AS_CRC];
	assign force_autostop_timeout_error = pulse[`SDFE_B_AS_TIMEOUT];
	assign force_autostop_not_executed  = pulse[`SDFE_B_AS_NOTEXEC];

	// ----------------------------------------
	// length mismatch flag
	// ----------------------------------------
	always_comb
	begin
		next_dma_length_mismatch = dma_length_mismatch;
		// set wins over the hardware clear so a late mismatch is not lost
		if (dma_len_mismatch_clr)
			next_dma_length_mismatch = 1'b0;
		if (dma_len_mismatch_set)
			next_dma_length_mismatch = 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dma_length_mismatch <= 1'b0;
		else
			dma_length_mismatch <= next_dma_length_mismatch;
	end

	// ----------------------------------------
	// dma error state
	// ----------------------------------------
	always_comb
	begin
		next_dma_error_state = dma_error_state;
		// the reserved code is stored as given; filtering it would hide an engine fault
		if (dma_err_event)
			next_dma_error_state = dma_err_state;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dma_error_state <= `SDFE_STATE_STOP;
		else
			dma_error_state <= next_dma_error_state;
	end

	// ----------------------------------------
	// descriptor pointer
	// ----------------------------------------
	always_comb
	begin
		next_dma_descriptor_pointer = dma_descriptor_pointer;
		if (ptr_wr)
			next_dma_descriptor_pointer = reg_wdata;
		// engine advance beats software load: it reflects the live descriptor
		if (dma_ptr_update)
			next_dma_descriptor_pointer = dma_ptr_value;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dma_descriptor_pointer <= `SDFE_RST_WORD;
		else
			dma_descriptor_pointer <= next_dma_descriptor_pointer;
	end

	// ----------------------------------------
	// register words
	// ----------------------------------------
	// unimplemented upper bits are tied low once here, so no read path can leak them
	assign maxcap_word   = {24'h000000, MAX_CURRENT};
	assign dma_stat_word = {29'h00000000, dma_length_mismatch, dma_error_state};

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb
	begin
		next_reg_rdata = `SDFE_RST_WORD;
		// data returns to zero between reads so a stale word never lingers on the bus
		if (reg_rd)
		begin
			unique case (reg_addr)
				`SDFE_OFS_MAXCAP:   next_reg_rdata = maxcap_word;
				`SDFE_OFS_FORCE:    next_reg_rdata = `SDFE_RST_WORD;
				`SDFE_OFS_DMA_STAT: next_reg_rdata = dma_stat_word;
				`SDFE_OFS_DMA_ADDR: next_reg_rdata = dma_descriptor_pointer;
				default:            next_reg_rdata = `SDFE_RST_WORD;
			endcase
		end
	end

	// registered read data: valid in the cycle after the read strobe
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= `SDFE_RST_WORD;
		else
			reg_rdata <= next_reg_rdata;
	end
endmodule // sdfe_bank
`default_nettype wire

// ---- sdfe_bank_asserts.sv ----
// port assertions for the force event / dma status bank
`timescale 1ns/100ps
`default_nettype none
module sdfe_bank_chk
	import sdfe_pkg::*;
#(
	parameter logic [7:0] MAX_CURRENT = 8'h01
)
(
	input wire logic            clk,
	input wire logic            rst_n,
	input wire logic            reg_wr,
	input wire logic            reg_rd,
	input wire logic [7:0]      reg_addr,
	input wire sdfe_word_t      reg_wdata,
	input wire sdfe_word_t      reg_rdata,
	input wire logic            dma_err_event,
	input wire sdfe_dma_state_t dma_err_state,
	input wire logic            dma_ptr_update,
	input wire sdfe_word_t      dma_ptr_value,
	input wire sdfe_word_t      dma_descriptor_pointer,
	input wire logic            force_dma_error,
	input wire logic            force_current_limit_error,
	input wire logic            force_autostop_not_executed
);
	wire logic fw = reg_wr && reg_addr == 8'h04;
	wire logic fw23 = fw && reg_wdata[23];
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_dma_force: assert property (fw && reg_wdata[25] |=> force_dma_error)
		else $error("dma force pulse missing");
	a_limit_cause: assert property (force_current_limit_error |-> $past(fw23))
		else $error("limit pulse without write");
	a_notexec_force: assert property (fw && reg_wdata[0] |=> force_autostop_not_executed)
		else $error("not executed pulse missing");
	a_maxcap_read: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == {24'h000000, MAX_CURRENT})
		else $error("max current read wrong");
	a_force_reads: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == 32'h00000000)
		else $error("force register read not zero");
	a_ptr_load: assert property (dma_ptr_update |=> dma_descriptor_pointer == $past(dma_ptr_value))
		else $error("pointer not loaded");
	a_ptr_hold: assert property (!dma_ptr_update && !(reg_wr && reg_addr == 8'h0C) |=>
		$stable(dma_descriptor_pointer))
		else $error("pointer changed");
	a_state_read: assert property (dma_err_event ##1 (reg_rd && reg_addr == 8'h08) |=>
		reg_rdata[1:0] == $past(dma_err_state, 2))
		else $error("dma state read wrong");
	cover property (force_dma_error);
	cover property (dma_err_event && dma_err_state == 2'h3);
	cover property (dma_ptr_update && reg_wr);
endmodule // sdfe_bank_chk
bind sdfe_bank sdfe_bank_chk #(.MAX_CURRENT(MAX_CURRENT)) u_sdfe_bank_chk (.clk, .rst_n, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_rdata, .dma_err_event, .dma_err_state, .dma_ptr_update, .dma_ptr_value,
	.dma_descriptor_pointer, .force_dma_error, .force_current_limit_error, .force_autostop_not_executed);
`default_nettype wire

// ---- sdfe_bank_tb.sv ----
// self-checking bench for the force event / dma status bank
`timescale 1ns/100ps
`default_nettype none
module sdfe_bank_tb;
	import sdfe_pkg::*;
	localparam logic [7:0] MC = 8'h04;
	logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, dma_err_event = 0, dma_ptr_update = 0;
	logic dma_len_mismatch_set = 0, dma_len_mismatch_clr = 0;
	logic [7:0] reg_addr = 0;
	sdfe_dma_state_t dma_err_state = 0;
	sdfe_word_t reg_wdata = 0, dma_ptr_value = 0, d;
	wire sdfe_word_t reg_rdata, dma_descriptor_pointer;
	wire logic [15:0] f;
	int mismatches = 0, checks_done = 0;
	always #5 clk = ~clk;
	sdfe_bank #(.MAX_CURRENT(MC)) u_sdfe_bank (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.dma_err_event, .dma_err_state, .dma_len_mismatch_set, .dma_len_mismatch_clr, .dma_ptr_update,
		.dma_ptr_value, .dma_descriptor_pointer, .force_dma_error(f[15]), .force_autostop_error(f[14]),
		.force_current_limit_error(f[13]), .force_data_endbit_error(f[12]), .force_data_crc_error(f[11]),
		.force_data_timeout_error(f[10]), .force_cmd_index_error(f[9]), .force_cmd_endbit_error(f[8]),
		.force_cmd_crc_error(f[7]), .force_cmd_timeout_error(f[6]), .force_cmd_not_issued_error(f[5]),
		.force_autostop_index_error(f[4]), .force_autostop_endbit_error(f[3]), .force_autostop_crc_error(f[2]),
		.force_autostop_timeout_error(f[1]), .force_autostop_not_executed(f[0]));
	// unimplemented force bits simply drop out of the packed pulse vector
	function automatic logic [15:0] fx(input sdfe_word_t w);
		return {w[25:16], w[7], w[4:0]};
	endfunction
	task automatic chk(input sdfe_word_t got, input sdfe_word_t exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// holds the request one cycle; callers chain it so strobes never toggle twice in one step
	task automatic acc(input logic w, input logic r, input logic [7:0] a, input sdfe_word_t v);
		reg_wr = w;
		reg_rd = r;
		reg_addr = a;
		reg_wdata = v;
		@(negedge clk);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		void'($urandom(22));
		repeat (3) @(negedge clk);
		rst_n = 1;
		acc(1, 0, 8'h00, 32'hFFFFFFFF);
		acc(1, 0, 8'h10, 32'hFFFFFFFF);
		for (int a = 0; a < 20; a += 4)
		begin
			acc(0, 1, 8'(a), 0);
			chk(reg_rdata, (a == 0) ? {24'h000000, MC} : 32'h00000000);
		end
		for (int i = 0; i < 52; i++)
		begin
			d = (i < 32) ? 32'h00000001 << i : $urandom;
			acc(1, 0, 8'h04, d);
			chk(32'(f), 32'(fx(d)));
			acc(1, 1, 8'h04, ~d);
			chk(reg_rdata, 32'h00000000);
			chk(32'(f), 32'(fx(~d)));
			acc(0, 0, 8'h04, 0);
			chk(reg_rdata | 32'(f), 32'h00000000);
		end
		for (int s = 0; s < 4; s++)
		begin
			dma_err_event = 1;
			dma_err_state = 2'(s);
			dma_len_mismatch_set = (s == 1 || s == 2);
			dma_len_mismatch_clr = (s >= 2);
			acc(0, 0, 8'h00, 0);
			dma_err_event = 0;
			dma_len_mismatch_set = 0;
			dma_len_mismatch_clr = 0;
			acc(0, 1, 8'h08, 0);
			chk(reg_rdata, {29'h0, (s == 1 || s == 2), 2'(s)});
		end
		repeat (20)
		begin
			d = $urandom;
			dma_ptr_value = ~d;
			dma_ptr_update = d[0];
			acc(1, 0, 8'h0C, d);
			dma_ptr_update = 0;
			acc(0, 1, 8'h0C, 0);
			chk(reg_rdata, d[0] ? ~d : d);
			chk(dma_descriptor_pointer, d[0] ? ~d : d);
		end
		// mid-run reset must return status and pointer to zero
		rst_n = 1'h0;
		@(negedge clk);
		rst_n = 1'h1;
		acc(1'h0, 1'h1, 8'h08, 32'h00000000);
		chk(reg_rdata, 32'h00000000);
		acc(1'h0, 1'h1, 8'h0C, 32'h00000000);
		chk(reg_rdata, 32'h00000000);
		chk(dma_descriptor_pointer, 32'h00000000);
		acc(0, 0, 8'h00, 0);
		summarize();
	end
endmodule // sdfe_bank_tb
`default_nettype wire
